// *** mspt_pkg.sv ***
// Package for the main storage pattern test block: constants, types and map
package mspt_pkg;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 32;
   localparam int INV_BIT = 16;
   localparam logic [DATA_W-1:0] PAT_ONES = 32'hFFFFFFFF;
   localparam logic [DATA_W-1:0] PAT_ZEROS = 32'h00000000;
   localparam logic [DATA_W-1:0] PAT_WORST = 32'hAAAA5555;
   localparam logic [DATA_W-1:0] PAT_WORST_REV = 32'h5555AAAA;
   localparam logic [ADDR_W-1:0] ADDR_LAST_RST = 19'h7FFFF;
   // Register map, word aligned byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0C;
   localparam logic [7:0] OFS_LAST = 8'h10;
   localparam logic [7:0] OFS_ADDR = 8'h14;
   // Control fields
   localparam int CTRL_SEL_LSB = 0;
   localparam int CTRL_WRITE = 3;
   localparam int CTRL_STOP_CHK = 4;
   localparam int CTRL_INVERT = 5;
   localparam int CTRL_START = 8;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   // Interrupt bits: done, halted by check, error seen
   localparam int IRQ_DONE = 0;
   localparam int IRQ_HALT = 1;
   localparam int IRQ_ERR = 2;
   localparam logic [3:0] MASK_RST = 4'h0;
   typedef enum logic [2:0] {SEL_PROCESS, SEL_ONES, SEL_ZEROS, SEL_WORST, SEL_WORST_REV} mspt_sel_t;
   typedef enum {ST_IDLE, ST_FILL} mspt_state_t;
   typedef struct packed {
      logic wr;
      logic prot_bypass;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mspt_store_req_t;
endpackage : mspt_pkg

// *** mspt_storage_model.sv ***
// Storage array model taking fill writes and flagging a check on request
`timescale 1ns/10ps
module mspt_storage_model
   import mspt_pkg::*;
(
   input wire logic clk,
   input wire mspt_pkg::mspt_store_req_t store_q,
   input wire logic err_en,
   output logic storage_error
);
   logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
   int writes;
   int bad;
   logic [ADDR_W-1:0] next_addr;
   // A weak word at address 5 fails when written, only if the bench asks
   assign storage_error = err_en && store_q.wr && (store_q.addr == 19'h00005);
   task automatic clear;
      mem.delete();
      writes = 0;
      bad = 0;
      next_addr = '0;
   endtask : clear
   // Keeps each write; counts any out of order or still protected
   always @(posedge clk)
   begin
      if (store_q.wr === 1'b1)
      begin
         if (store_q.addr !== next_addr || store_q.prot_bypass !== 1'b1)
            bad++;
         mem[store_q.addr] = store_q.data;
         next_addr = store_q.addr + 1'b1;
         writes++;
      end
   end
endmodule : mspt_storage_model

// *** mspt_top.sv ***
// Main storage pattern test: fill engine, address inversion and register slave
`timescale 1ns/10ps
module mspt_top
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sys_reset,
   input wire logic storage_error,
   input wire logic [mspt_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output mspt_pkg::mspt_store_req_t store_q,
   output logic [mspt_pkg::ADDR_W-1:0] storage_address_register,
   output logic test_lamp,
   output logic irq
);
   import mspt_pkg::*;

   logic rst_s1_q;
   logic rst_s2_q;
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [2:0] status_q;
   logic [2:0] mask_q;
   logic [ADDR_W-1:0] last_q;
   mspt_state_t state_q;
   mspt_state_t state_d;
   logic [ADDR_W-1:0] fill_addr_q;
   logic dph_wr_q;
   logic [7:0] dph_ofs_q;
   logic [31:0] rd_mux;
   logic [31:0] rd_next;

   // Reset released through two flops; the asserting edge stays asynchronous
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end

   // Bus address phase accept and data phase write decode
   wire addr_take = hsel && hready && htrans[1];
   wire wr_ctrl = dph_wr_q && (dph_ofs_q == OFS_CTRL);
   wire wr_irq = dph_wr_q && (dph_ofs_q == OFS_IRQ);
   wire wr_mask = dph_wr_q && (dph_ofs_q == OFS_MASK);
   wire wr_last = dph_wr_q && (dph_ofs_q == OFS_LAST);

   // Control field decode
   wire [2:0] sel_raw = ctrl_q[CTRL_SEL_LSB +: 3];
   wire write_key = ctrl_q[CTRL_WRITE];
   wire stop_chk = ctrl_q[CTRL_STOP_CHK];
   wire invert_key = ctrl_q[CTRL_INVERT];
   wire start_pulse = wr_ctrl && hwdata[CTRL_START];
   wire filling = (state_q == ST_FILL);

   // Pattern choice; unused selector codes cannot start a fill, yet still light the test lamp
   logic [DATA_W-1:0] pattern;
   always_comb
   begin
      case (sel_raw)
         3'(SEL_ONES): pattern = PAT_ONES;
         3'(SEL_ZEROS): pattern = PAT_ZEROS;
         3'(SEL_WORST): pattern = PAT_WORST;
         3'(SEL_WORST_REV): pattern = PAT_WORST_REV;
         default: pattern = PAT_ZEROS;
      endcase
   end
   wire sel_test = (sel_raw >= 3'(SEL_ONES)) && (sel_raw <= 3'(SEL_WORST_REV));

   // Termination causes
   wire chk_stop = filling && storage_error && stop_chk;
   wire at_last = filling && (fill_addr_q == last_q);
   wire begin_fill = (state_q == ST_IDLE) && start_pulse && write_key && sel_test && !sys_reset;

   // Fill sequencer
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: if (begin_fill) state_d = ST_FILL;
         ST_FILL: if (sys_reset || chk_stop || at_last) state_d = ST_IDLE;
         default: state_d = ST_IDLE;
      endcase
   end

   // Address source: the fill counter during a test, the processor otherwise
   wire [ADDR_W-1:0] raw_addr = filling ? fill_addr_q : cpu_addr;
   wire [ADDR_W-1:0] inv_mask = invert_key ? (ADDR_W'(1) << INV_BIT) : '0;
   wire [ADDR_W-1:0] eff_addr = raw_addr ^ inv_mask;

   // Sticky events; a new event beats a write-one clear in the same cycle
   wire [2:0] evt = {filling && storage_error, chk_stop, filling && at_last && !chk_stop && !sys_reset};
   wire [2:0] status_d = (status_q & ~(wr_irq ? hwdata[2:0] : 3'h0)) | evt;

   // Control register; start is a self-clearing strobe and never stored
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_ctrl)
         ctrl_d = {26'h0, hwdata[5:0]};
   end

   always_ff @(posedge clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         state_q <= ST_IDLE;
         fill_addr_q <= '0;
         ctrl_q <= CTRL_RST;
         status_q <= 3'h0;
         mask_q <= MASK_RST[2:0];
         last_q <= ADDR_LAST_RST;
      end
      else
      begin
         state_q <= state_d;
         fill_addr_q <= begin_fill ? '0 : (filling ? fill_addr_q + 1'b1 : fill_addr_q);
         ctrl_q <= ctrl_d;
         status_q <= status_d;
         if (wr_mask)
            mask_q <= hwdata[2:0];
         if (wr_last)
            last_q <= hwdata[ADDR_W-1:0];
      end
   end

   // Storage port and lamps, all registered
   always_ff @(posedge clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         store_q <= '0;
         storage_address_register <= '0;
         test_lamp <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         store_q.wr <= filling;
         store_q.prot_bypass <= filling;
         store_q.addr <= eff_addr;
         store_q.data <= pattern;
         storage_address_register <= eff_addr;
         test_lamp <= (sel_raw != 3'(SEL_PROCESS));
         irq <= |(status_d & mask_q);
      end
   end

   // Read mux on the address phase, so read data leaves a flop in the data phase.
   // Limitation: a read right behind a write to the same register sees the old value.
   always_comb
   begin
      case (haddr[7:0])
         OFS_CTRL: rd_mux = ctrl_q;
         OFS_STAT: rd_mux = {30'h0, sel_test, filling};
         OFS_IRQ: rd_mux = {29'h0, status_q};
         OFS_MASK: rd_mux = {29'h0, mask_q};
         OFS_LAST: rd_mux = {13'h0, last_q};
         OFS_ADDR: rd_mux = {13'h0, fill_addr_q};
         default: rd_mux = 32'h00000000;
      endcase
   end
   assign rd_next = (addr_take && !hwrite) ? rd_mux : 32'h00000000;

   // Bus data phase capture; zero wait states, always OKAY, all outputs registered
   always_ff @(posedge clk or negedge rst_s2_q)
   begin
      if (!rst_s2_q)
      begin
         dph_wr_q <= 1'b0;
         dph_ofs_q <= 8'h00;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         dph_wr_q <= addr_take && hwrite;
         dph_ofs_q <= haddr[7:0];
         hrdata <= rd_next;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // Checks
   chk_fill_write: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling |=> store_q.wr && store_q.prot_bypass) else $error("fill write missing");
   chk_reset_ends: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling && sys_reset |=> !filling) else $error("reset did not end test");
   chk_stop_check: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling && storage_error && stop_chk |=> state_q == ST_IDLE) else $error("check did not halt");
   chk_no_stop: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling && storage_error && !stop_chk && !sys_reset && !at_last |=> filling) else $error("halted");
   chk_addr_invert: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling && invert_key |=> store_q.addr[INV_BIT] != $past(fill_addr_q[INV_BIT])) else $error("bit 16");
   chk_block_swap: assert property (@(posedge clk) disable iff (!rst_s2_q)
      1'b1 |=> store_q.addr[15:0] == $past(raw_addr[15:0])) else $error("low bits altered");
   chk_lamp_sel: assert property (@(posedge clk) disable iff (!rst_s2_q)
      1'b1 |=> test_lamp == ($past(sel_raw) != 3'h0)) else $error("lamp wrong");
   sequence s_step;
      filling && !at_last && !sys_reset && !chk_stop;
   endsequence
   chk_addr_step: assert property (@(posedge clk) disable iff (!rst_s2_q)
      s_step |=> fill_addr_q == $past(fill_addr_q) + 1'b1) else $error("fill skipped");
   chk_pattern_ones: assert property (@(posedge clk) disable iff (!rst_s2_q)
      sel_raw == 3'h1 |=> store_q.data == PAT_ONES) else $error("pattern wrong");
   chk_pattern_zeros: assert property (@(posedge clk) disable iff (!rst_s2_q)
      sel_raw == 3'h2 |=> store_q.data == PAT_ZEROS) else $error("zeros wrong");
   chk_pattern_worst: assert property (@(posedge clk) disable iff (!rst_s2_q)
      sel_raw == 3'h3 |=> store_q.data == PAT_WORST) else $error("worst wrong");
   chk_pattern_rev: assert property (@(posedge clk) disable iff (!rst_s2_q)
      sel_raw == 3'h4 |=> store_q.data == PAT_WORST_REV) else $error("reverse wrong");
   // A fill starts at the lowest address and writes nothing while idle
   chk_fill_begins: assert property (@(posedge clk) disable iff (!rst_s2_q)
      begin_fill |=> filling && fill_addr_q == '0) else $error("fill start wrong");
   chk_idle_quiet: assert property (@(posedge clk) disable iff (!rst_s2_q)
      !filling |=> !store_q.wr) else $error("write while idle");
   sequence s_last_clean;
      filling && at_last && !sys_reset && !chk_stop;
   endsequence
   chk_last_ends: assert property (@(posedge clk) disable iff (!rst_s2_q)
      s_last_clean |=> !filling && status_q[IRQ_DONE]) else $error("fill ran past last");
   chk_err_sticky: assert property (@(posedge clk) disable iff (!rst_s2_q)
      filling && storage_error |=> status_q[IRQ_ERR]) else $error("error not kept");
   chk_sar_follow: assert property (@(posedge clk) disable iff (!rst_s2_q)
      1'b1 |=> storage_address_register == $past(eff_addr)) else $error("address wrong");
   chk_irq_level: assert property (@(posedge clk) disable iff (!rst_s2_q)
      1'b1 |=> irq == $past(|(status_d & mask_q))) else $error("irq wrong");
endmodule : mspt_top

// *** test_main_storage_pattern_test.sv ***
// Self-checking bench for the main storage pattern test block
`timescale 1ns/10ps
module test_main_storage_pattern_test;
   import mspt_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_reset = 1'b0;
   logic err_en = 1'b0;
   logic [ADDR_W-1:0] cpu_addr = 19'h14123;
   logic [31:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic storage_error;
   logic [ADDR_W-1:0] storage_address_register;
   logic hresp;
   logic test_lamp;
   logic irq;
   logic [31:0] r;
   mspt_store_req_t store_q;
   int failures = 0;
   int compares = 0;
   logic [34:0] rows [4] = '{{3'h1, PAT_ONES}, {3'h2, PAT_ZEROS}, {3'h3, PAT_WORST}, {3'h4, PAT_WORST_REV}};
   // Clock at 100 MHz
   always #5 clk = ~clk;
   mspt_top mspt_top_inst (.clk(clk), .rst_n(rst_n), .sys_reset(sys_reset), .storage_error(storage_error),
      .cpu_addr(cpu_addr), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .store_q(store_q), .storage_address_register(storage_address_register), .test_lamp(test_lamp), .irq(irq));
   mspt_storage_model mspt_storage_model_inst (.clk(clk), .store_q(store_q), .err_en(err_en),
      .storage_error(storage_error));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   // Single word transfer; ends at a falling edge so registered outputs settle
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
      @(posedge clk);
      @(posedge clk);
      @(negedge clk);
   endtask : xfer
   // Key goes in first, start needs it already stored
   task automatic go(input logic [31:0] c);
      mspt_storage_model_inst.clear();
      xfer(1'b1, OFS_CTRL, c);
      xfer(1'b1, OFS_CTRL, c | 32'h100);
   endtask : go
   task automatic wait_idle;
      r = 32'h1;
      for (int n = 0; n < 99 && r[0] !== 1'b0; n++)
         xfer(1'b0, OFS_STAT, 32'h0);
      chk({31'h0, r[0]}, 32'h0);
   endtask : wait_idle
   task automatic end_of_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_of_test
   // Watchdog far beyond the few hundred cycles the tests need
   initial
   begin
      #200000;
      failures++;
      end_of_test();
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk({test_lamp, irq, store_q.wr}, 3'h0);
      xfer(1'b0, OFS_LAST, 32'h0);
      chk(r, {13'h0, ADDR_LAST_RST});
      chk(hresp, 1'b0);
      xfer(1'b1, 8'h40, 32'hFFFFFFFF);
      xfer(1'b0, 8'h40, 32'h0);
      chk(r, 32'h0);
      xfer(1'b1, OFS_LAST, 32'hF);
      // Every pattern fills the shortened storage, interrupt still masked
      for (int i = 0; i < 4; i++)
      begin
         go({29'h0, rows[i][34:32]} | 32'h8);
         wait_idle();
         chk(r, 32'h2);
         chk(mspt_storage_model_inst.writes, 16);
         chk(mspt_storage_model_inst.bad, 0);
         for (int a = 0; a < 16; a++)
            chk(mspt_storage_model_inst.mem[19'(a)], rows[i][31:0]);
         chk(irq, 1'b0);
         xfer(1'b0, OFS_IRQ, 32'h0);
         chk(r, 32'h1);
         xfer(1'b1, OFS_IRQ, 32'h7);
      end
      $display("test patterns done");
      go(32'h9);
      wait_idle();
      xfer(1'b1, OFS_MASK, 32'h1);
      chk(irq, 1'b1);
      xfer(1'b1, OFS_IRQ, 32'h1);
      chk(irq, 1'b0);
      $display("test interrupt done");
      // A check halts the fill only with stop-on-check set
      err_en <= 1'b1;
      for (int s = 0; s < 2; s++)
      begin
         go(32'h9 | (s << CTRL_STOP_CHK));
         wait_idle();
         chk(mspt_storage_model_inst.writes < 16, s == 1);
         xfer(1'b0, OFS_IRQ, 32'h0);
         chk(r[2:1], {1'b1, s[0]});
         xfer(1'b1, OFS_IRQ, 32'h7);
      end
      err_en <= 1'b0;
      $display("test stop on check done");
      go(32'h9);
      repeat (4) @(posedge clk);
      sys_reset <= 1'b1;
      @(posedge clk);
      sys_reset <= 1'b0;
      wait_idle();
      chk(mspt_storage_model_inst.writes < 16, 1'b1);
      $display("test system reset done");
      // Inverted fill lands in the other 64K half; only the first write jumps
      go(32'h29);
      wait_idle();
      chk(mspt_storage_model_inst.writes, 16);
      chk(mspt_storage_model_inst.bad, 1);
      chk(mspt_storage_model_inst.mem[19'h10003], PAT_ONES);
      chk(mspt_storage_model_inst.mem[19'h1000F], PAT_ONES);
      $display("test inverted fill done");
      // Selector 0 then 5 with inversion: lamp and bit 16 follow
      for (int k = 0; k < 2; k++)
      begin
         xfer(1'b1, OFS_CTRL, k * 32'h25);
         chk(test_lamp, k[0]);
         chk(storage_address_register, 19'h14123 ^ (k << INV_BIT));
      end
      $display("test lamp and inversion done");
      end_of_test();
   end
endmodule : test_main_storage_pattern_test
